// ==== hw/cimb_pkg.sv ====
// Constants and state types of the charger interrupt mask bank.
// Assumes one clock domain; all users refer to items as cimb_pkg::name.
//
// What this block does
// [RULE1] A clear mask bit lets its flag drive the interrupt; a set bit blocks it.
// [RULE2] First mask bits 7..0: battery voltage and current, output voltage and bus voltage protections.
// [RULE3] Second mask: bus current bits 7..4, cap short bit 2, reserved bits 3,1 writable, 0 fixed.
// [RULE4] Third mask bits 7..0: input overvoltage, presence and input switch config masks.
// [RULE5] First mask at 1Dh, zero at power-up and after the register-reset command.
// [RULE6] Second mask at 1Eh, zero at power-up and after the register-reset command.
// [RULE7] Third mask at 1Fh, zero at power-up and after the register-reset command.
// [RULE8] Fourth mask register exists at 20h with reset value zero.
// [RULE9] Flags are read-only, read zero normally and one after a status change.
// [RULE10] Interrupt asserts when any flag is set with its mask clear.

package cimb_pkg;

  // Register byte offsets
  localparam logic [7:0] FLAG1_OFS = 8'h18;
  localparam logic [7:0] FLAG2_OFS = 8'h19;
  localparam logic [7:0] FLAG3_OFS = 8'h1a;
  localparam logic [7:0] FLAG4_OFS = 8'h1b;
  localparam logic [7:0] BATTERY_BUS_PROTECT_MASK_OFS = 8'h1d;
  localparam logic [7:0] BUS_CURRENT_CAP_MASK_OFS     = 8'h1e;
  localparam logic [7:0] INPUT_PRESENCE_MASK_OFS      = 8'h1f;
  localparam logic [7:0] THERMAL_ADC_WATCH_MASK_OFS   = 8'h20;

  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE  = 8'h00;

  // Writable mask bits and implemented flag bits per lane
  localparam logic [7:0] MASK1_WR_BITS = 8'hff;
  localparam logic [7:0] MASK2_WR_BITS = 8'hfe;
  localparam logic [7:0] MASK3_WR_BITS = 8'hff;
  localparam logic [7:0] MASK4_WR_BITS = 8'hff;
  localparam logic [7:0] FLAG1_BITS    = 8'hff;
  localparam logic [7:0] FLAG2_BITS    = 8'hf4;
  localparam logic [7:0] FLAG3_BITS    = 8'hff;
  localparam logic [7:0] FLAG4_BITS    = 8'hff;

  // First mask field positions
  localparam int BATTERY_OVERVOLTAGE_IRQ_BLOCK        = 7;
  localparam int BATTERY_OVERVOLTAGE_ALARM_IRQ_BLOCK  = 6;
  localparam int OUTPUT_OVERVOLTAGE_IRQ_BLOCK         = 5;
  localparam int BATTERY_OVERCURRENT_IRQ_BLOCK        = 4;
  localparam int BATTERY_OVERCURRENT_ALARM_IRQ_BLOCK  = 3;
  localparam int BATTERY_UNDERCURRENT_ALARM_IRQ_BLOCK = 2;
  localparam int BUS_OVERVOLTAGE_IRQ_BLOCK            = 1;
  localparam int BUS_OVERVOLTAGE_ALARM_IRQ_BLOCK      = 0;
  localparam int BATTERY_OVERVOLTAGE_EVENT            = 7;

  // Second mask field positions
  localparam int BUS_OVERCURRENT_IRQ_BLOCK       = 7;
  localparam int BUS_OVERCURRENT_ALARM_IRQ_BLOCK = 6;
  localparam int BUS_UNDERCURRENT_IRQ_BLOCK      = 5;
  localparam int BUS_REVERSE_CURRENT_IRQ_BLOCK   = 4;
  localparam int FLYING_CAP_SHORT_IRQ_BLOCK      = 2;

  // Third mask field positions
  localparam int INPUT_ONE_OVERVOLTAGE_IRQ_BLOCK = 7;
  localparam int INPUT_TWO_OVERVOLTAGE_IRQ_BLOCK = 6;
  localparam int OUTPUT_PRESENT_IRQ_BLOCK        = 5;
  localparam int INPUT_ONE_PRESENT_IRQ_BLOCK     = 4;
  localparam int INPUT_TWO_PRESENT_IRQ_BLOCK     = 3;
  localparam int BUS_PRESENT_IRQ_BLOCK           = 2;
  localparam int INPUT_SWITCH_ONE_CFG_IRQ_BLOCK  = 1;
  localparam int INPUT_SWITCH_TWO_CFG_IRQ_BLOCK  = 0;

  // State of one mask and flag lane
  typedef struct packed {
    logic [7:0] mask_r;
    logic [7:0] flag_r;
  } cimb_lane_t;

  // State of the bank top
  typedef struct packed {
    logic [7:0] rd_data_r;
    logic       irq_r;
  } cimb_top_t;

endpackage : cimb_pkg

// ==== hw/cimb_flag_lane.sv ====
// One mask register with up to eight sticky flags, as FLAG_BITS allows, and pending term.
// Assumes events and register strobes come from logic on clk.

module cimb_flag_lane #(
  parameter logic [7:0] WR_BITS   = 8'hff,
  parameter logic [7:0] FLAG_BITS = 8'hff
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register access
  input  wire logic       reg_clr,
  input  wire logic       mask_we,
  input  wire logic [7:0] wdata,
  input  wire logic       flag_rd,
  // Status changes from monitoring logic
  input  wire logic [7:0] event_in,
  // Lane state
  output logic [7:0]      mask_q,
  output logic [7:0]      flag_q,
  output logic            pending
);

  cimb_pkg::cimb_lane_t st_r;
  cimb_pkg::cimb_lane_t st_nxt;

  // Mask writes, command clear and sticky flags
  always_comb begin
    st_nxt = st_r;
    if (reg_clr) begin
      st_nxt.mask_r = cimb_pkg::MASK_RESET;                  // [RULE5] [RULE6] [RULE7] [RULE8]
    end else if (mask_we) begin
      st_nxt.mask_r = wdata & WR_BITS;                       // [RULE3]
    end
    // Read clears, but a change in the same cycle wins so none is lost
    if (flag_rd) begin
      st_nxt.flag_r = cimb_pkg::FLAG_RESET;
    end
    st_nxt.flag_r = (st_nxt.flag_r | event_in) & FLAG_BITS; // [RULE9]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.mask_r <= cimb_pkg::MASK_RESET;                   // [RULE5] [RULE6] [RULE7] [RULE8]
      st_r.flag_r <= cimb_pkg::FLAG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mask_q  = st_r.mask_r;
  assign flag_q  = st_r.flag_r;
  assign pending = |(st_r.flag_r & ~st_r.mask_r);          // [RULE1]

endmodule : cimb_flag_lane

// ==== hw/cimb_mask_bank.sv ====
// Interrupt mask bank: four mask registers, four flag registers, one interrupt.
// Assumes a register port driven by the serial register interface on clk,
// and status-change pulses from on-chip monitors on the same clock.

module cimb_mask_bank (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Register-reset command
  input  wire logic       reg_reset_cmd,
  // Status-change pulses, one bit per flag
  input  wire logic [7:0] protect_events,
  input  wire logic [7:0] bus_current_events,
  input  wire logic [7:0] input_presence_events,
  input  wire logic [7:0] thermal_adc_events,
  // Interrupt to the host
  output logic            irq
);

  cimb_pkg::cimb_top_t st_r;
  cimb_pkg::cimb_top_t st_nxt;

  logic [7:0] mask1_q;
  logic [7:0] mask2_q;
  logic [7:0] mask3_q;
  logic [7:0] mask4_q;
  logic [7:0] flag1_q;
  logic [7:0] flag2_q;
  logic [7:0] flag3_q;
  logic [7:0] flag4_q;
  logic       pend1;
  logic       pend2;
  logic       pend3;
  logic       pend4;

  // Address decode of write and read strobes
  logic we1;
  logic we2;
  logic we3;
  logic we4;
  logic rd1;
  logic rd2;
  logic rd3;
  logic rd4;

  assign we1 = reg_wr && (reg_addr == cimb_pkg::BATTERY_BUS_PROTECT_MASK_OFS); // [RULE5]
  assign we2 = reg_wr && (reg_addr == cimb_pkg::BUS_CURRENT_CAP_MASK_OFS);     // [RULE6]
  assign we3 = reg_wr && (reg_addr == cimb_pkg::INPUT_PRESENCE_MASK_OFS);      // [RULE7]
  assign we4 = reg_wr && (reg_addr == cimb_pkg::THERMAL_ADC_WATCH_MASK_OFS);   // [RULE8]
  // Flag reads clear the register they read
  assign rd1 = reg_rd && (reg_addr == cimb_pkg::FLAG1_OFS);
  assign rd2 = reg_rd && (reg_addr == cimb_pkg::FLAG2_OFS);
  assign rd3 = reg_rd && (reg_addr == cimb_pkg::FLAG3_OFS);
  assign rd4 = reg_rd && (reg_addr == cimb_pkg::FLAG4_OFS);

  // First three mask read words rebuilt field by field, the fourth reads as stored; a bit without a field reads zero, except bits 3 and 1 of the second mask
  logic [7:0] mask1_view;
  logic [7:0] mask2_view;
  logic [7:0] mask3_view;

  // Battery and bus protection mask fields
  always_comb begin
    mask1_view = cimb_pkg::MASK_RESET;                                   // [RULE2]
    mask1_view[cimb_pkg::BATTERY_OVERVOLTAGE_IRQ_BLOCK] =
      mask1_q[cimb_pkg::BATTERY_OVERVOLTAGE_IRQ_BLOCK];
    mask1_view[cimb_pkg::BATTERY_OVERVOLTAGE_ALARM_IRQ_BLOCK] =
      mask1_q[cimb_pkg::BATTERY_OVERVOLTAGE_ALARM_IRQ_BLOCK];
    mask1_view[cimb_pkg::OUTPUT_OVERVOLTAGE_IRQ_BLOCK] =
      mask1_q[cimb_pkg::OUTPUT_OVERVOLTAGE_IRQ_BLOCK];
    mask1_view[cimb_pkg::BATTERY_OVERCURRENT_IRQ_BLOCK] =
      mask1_q[cimb_pkg::BATTERY_OVERCURRENT_IRQ_BLOCK];
    mask1_view[cimb_pkg::BATTERY_OVERCURRENT_ALARM_IRQ_BLOCK] =
      mask1_q[cimb_pkg::BATTERY_OVERCURRENT_ALARM_IRQ_BLOCK];
    mask1_view[cimb_pkg::BATTERY_UNDERCURRENT_ALARM_IRQ_BLOCK] =
      mask1_q[cimb_pkg::BATTERY_UNDERCURRENT_ALARM_IRQ_BLOCK];
    mask1_view[cimb_pkg::BUS_OVERVOLTAGE_IRQ_BLOCK] =
      mask1_q[cimb_pkg::BUS_OVERVOLTAGE_IRQ_BLOCK];
    mask1_view[cimb_pkg::BUS_OVERVOLTAGE_ALARM_IRQ_BLOCK] =
      mask1_q[cimb_pkg::BUS_OVERVOLTAGE_ALARM_IRQ_BLOCK];
  end

  // Bus current mask fields; reserved bits that store have no flag behind them
  always_comb begin
    mask2_view = mask2_q & cimb_pkg::MASK2_WR_BITS & ~cimb_pkg::FLAG2_BITS; // [RULE3]
    mask2_view[cimb_pkg::BUS_OVERCURRENT_IRQ_BLOCK] =
      mask2_q[cimb_pkg::BUS_OVERCURRENT_IRQ_BLOCK];
    mask2_view[cimb_pkg::BUS_OVERCURRENT_ALARM_IRQ_BLOCK] =
      mask2_q[cimb_pkg::BUS_OVERCURRENT_ALARM_IRQ_BLOCK];
    mask2_view[cimb_pkg::BUS_UNDERCURRENT_IRQ_BLOCK] =
      mask2_q[cimb_pkg::BUS_UNDERCURRENT_IRQ_BLOCK];
    mask2_view[cimb_pkg::BUS_REVERSE_CURRENT_IRQ_BLOCK] =
      mask2_q[cimb_pkg::BUS_REVERSE_CURRENT_IRQ_BLOCK];
    mask2_view[cimb_pkg::FLYING_CAP_SHORT_IRQ_BLOCK] =
      mask2_q[cimb_pkg::FLYING_CAP_SHORT_IRQ_BLOCK];
  end

  // Input presence and switch config mask fields
  always_comb begin
    mask3_view = cimb_pkg::MASK_RESET;                                   // [RULE4]
    mask3_view[cimb_pkg::INPUT_ONE_OVERVOLTAGE_IRQ_BLOCK] =
      mask3_q[cimb_pkg::INPUT_ONE_OVERVOLTAGE_IRQ_BLOCK];
    mask3_view[cimb_pkg::INPUT_TWO_OVERVOLTAGE_IRQ_BLOCK] =
      mask3_q[cimb_pkg::INPUT_TWO_OVERVOLTAGE_IRQ_BLOCK];
    mask3_view[cimb_pkg::OUTPUT_PRESENT_IRQ_BLOCK] =
      mask3_q[cimb_pkg::OUTPUT_PRESENT_IRQ_BLOCK];
    mask3_view[cimb_pkg::INPUT_ONE_PRESENT_IRQ_BLOCK] =
      mask3_q[cimb_pkg::INPUT_ONE_PRESENT_IRQ_BLOCK];
    mask3_view[cimb_pkg::INPUT_TWO_PRESENT_IRQ_BLOCK] =
      mask3_q[cimb_pkg::INPUT_TWO_PRESENT_IRQ_BLOCK];
    mask3_view[cimb_pkg::BUS_PRESENT_IRQ_BLOCK] =
      mask3_q[cimb_pkg::BUS_PRESENT_IRQ_BLOCK];
    mask3_view[cimb_pkg::INPUT_SWITCH_ONE_CFG_IRQ_BLOCK] =
      mask3_q[cimb_pkg::INPUT_SWITCH_ONE_CFG_IRQ_BLOCK];
    mask3_view[cimb_pkg::INPUT_SWITCH_TWO_CFG_IRQ_BLOCK] =
      mask3_q[cimb_pkg::INPUT_SWITCH_TWO_CFG_IRQ_BLOCK];
  end

  // Battery and bus protection lane
  cimb_flag_lane #(
    .WR_BITS   (cimb_pkg::MASK1_WR_BITS),
    .FLAG_BITS (cimb_pkg::FLAG1_BITS)
  ) u_lane1 (
    .clk      (clk),
    .reset    (reset),
    .reg_clr  (reg_reset_cmd),
    .mask_we  (we1),
    .wdata    (reg_wdata),       // [RULE2]
    .flag_rd  (rd1),
    .event_in (protect_events),
    .mask_q   (mask1_q),
    .flag_q   (flag1_q),
    .pending  (pend1)
  );

  // Bus current and flying cap lane; bit 0 of its mask never stores
  cimb_flag_lane #(
    .WR_BITS   (cimb_pkg::MASK2_WR_BITS),
    .FLAG_BITS (cimb_pkg::FLAG2_BITS)
  ) u_lane2 (
    .clk      (clk),
    .reset    (reset),
    .reg_clr  (reg_reset_cmd),
    .mask_we  (we2),
    .wdata    (reg_wdata),       // [RULE3]
    .flag_rd  (rd2),
    .event_in (bus_current_events),
    .mask_q   (mask2_q),
    .flag_q   (flag2_q),
    .pending  (pend2)
  );

  // Input presence and switch config lane
  cimb_flag_lane #(
    .WR_BITS   (cimb_pkg::MASK3_WR_BITS),
    .FLAG_BITS (cimb_pkg::FLAG3_BITS)
  ) u_lane3 (
    .clk      (clk),
    .reset    (reset),
    .reg_clr  (reg_reset_cmd),
    .mask_we  (we3),
    .wdata    (reg_wdata),       // [RULE4]
    .flag_rd  (rd3),
    .event_in (input_presence_events),
    .mask_q   (mask3_q),
    .flag_q   (flag3_q),
    .pending  (pend3)
  );

  // Thermal, ADC and watchdog lane
  cimb_flag_lane #(
    .WR_BITS   (cimb_pkg::MASK4_WR_BITS),
    .FLAG_BITS (cimb_pkg::FLAG4_BITS)
  ) u_lane4 (
    .clk      (clk),
    .reset    (reset),
    .reg_clr  (reg_reset_cmd),
    .mask_we  (we4),
    .wdata    (reg_wdata),
    .flag_rd  (rd4),
    .event_in (thermal_adc_events),
    .mask_q   (mask4_q),
    .flag_q   (flag4_q),
    .pending  (pend4)
  );

  // Read mux and interrupt; unmapped offsets read zero
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_data_r = cimb_pkg::READ_IDLE;
    if (reg_rd) begin
      case (reg_addr)
        cimb_pkg::FLAG1_OFS:                    st_nxt.rd_data_r = flag1_q; // [RULE9]
        cimb_pkg::FLAG2_OFS:                    st_nxt.rd_data_r = flag2_q;
        cimb_pkg::FLAG3_OFS:                    st_nxt.rd_data_r = flag3_q;
        cimb_pkg::FLAG4_OFS:                    st_nxt.rd_data_r = flag4_q;
        cimb_pkg::BATTERY_BUS_PROTECT_MASK_OFS: st_nxt.rd_data_r = mask1_view;
        cimb_pkg::BUS_CURRENT_CAP_MASK_OFS:     st_nxt.rd_data_r = mask2_view;
        cimb_pkg::INPUT_PRESENCE_MASK_OFS:      st_nxt.rd_data_r = mask3_view;
        cimb_pkg::THERMAL_ADC_WATCH_MASK_OFS:   st_nxt.rd_data_r = mask4_q;
        default:                                st_nxt.rd_data_r = cimb_pkg::READ_IDLE;
      endcase
    end
    // Level interrupt: stays up until every unmasked flag is read away
    st_nxt.irq_r = pend1 | pend2 | pend3 | pend4; // [RULE10] [RULE1]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.rd_data_r <= cimb_pkg::READ_IDLE;
      st_r.irq_r     <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rd_data_r;
  assign irq       = st_r.irq_r;

endmodule : cimb_mask_bank

// ==== tb/cimb_mask_bank_props.sv ====
// Checker for the mask bank register port and interrupt.
// Assumes a bind to cimb_mask_bank; sees its ports only.
module cimb_mask_bank_props (
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_reset_cmd,
  // Status changes and interrupt
  input wire logic [7:0] protect_events,
  input wire logic [7:0] bus_current_events,
  input wire logic [7:0] input_presence_events,
  input wire logic [7:0] thermal_adc_events,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Any status change, a possible cause of irq rising
  wire logic any_ev = |{protect_events, bus_current_events, input_presence_events, thermal_adc_events};

  // Read data idles low
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  mask_echo_a: assert property (reg_wr && reg_addr == 8'h1d && !reg_reset_cmd ##1
    reg_rd && !reg_wr && !reg_reset_cmd && reg_addr == 8'h1d |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mask write not read back");
  mask2_bit0_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1e |-> !reg_rdata[0])
    else $error("fixed mask bit set");
  flag2_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h19 |->
    (reg_rdata & 8'h0b) == 8'h00)
    else $error("reserved flag bit set");
  regrst_clr_a: assert property (reg_reset_cmd ##1 !reg_wr ##1
    reg_rd && !reg_wr && reg_addr inside {[8'h1d:8'h20]} |=> reg_rdata == 8'h00)
    else $error("mask kept after register reset");
  // Irq moves only two edges after a cause
  irq_rise_a: assert property ($rose(irq) |-> $past(any_ev, 2) || $past(reg_wr, 2) ||
    $past(reg_reset_cmd, 2))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_rd, 2) || $past(reg_wr, 2))
    else $error("irq fell without cause");
  flag_sticky_a: assert property (protect_events[7] ##1 reg_rd && reg_addr == 8'h18 |=> reg_rdata[7])
    else $error("flag lost before read");
endmodule : cimb_mask_bank_props

// ==== tb/cimb_host_model.sv ====
// Host side of the register port: one-cycle strobes from falling edges.
// Assumes each call starts at a falling edge; idle() must end a run of calls.
module cimb_host_model (
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  // Register requests
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  output logic            reg_reset_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet port at time zero
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd, reg_reset_cmd} = '0;
  end
  // One request; the answer is taken one cycle later
  task automatic acc(input logic w, input logic r, input logic c, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    {reg_wr, reg_rd, reg_reset_cmd, reg_addr, reg_wdata} = {w, r, c, a, d};
    @(negedge clk);
    q = reg_rdata;
  endtask : acc
  // Released bus shows inverted values, so stale ones never look good
  task automatic idle();
    {reg_wr, reg_rd, reg_reset_cmd} = 3'b000;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(negedge clk);
  endtask : idle
endmodule : cimb_host_model

// ==== tb/cimb_mask_bank_tb.sv ====
// Bench for the mask bank: register values and irq for every flag.
// Assumes the host model drives the register port on falling edges.
module cimb_mask_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, m, f;
  logic       reg_wr, reg_rd, reg_reset_cmd, irq;
  logic [7:0] evs [4] = '{default: 8'h00};
  int         miscompares = 0;
  int         n_tests = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  cimb_mask_bank u_cimb_mask_bank (.clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_reset_cmd, .protect_events(evs[0]), .bus_current_events(evs[1]), .input_presence_events(evs[2]),
    .thermal_adc_events(evs[3]), .irq);
  cimb_host_model u_cimb_host_model (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_reset_cmd);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_irq(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t irq %b want %b", $time, got, exp);
    end
  endtask : chk_irq
  // Write, then read back on the next cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cimb_host_model.acc(1'b1, 1'b0, 1'b0, a, d, q);
    u_cimb_host_model.acc(1'b0, 1'b1, 1'b0, a, 8'h00, q);
    u_cimb_host_model.idle();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_cimb_host_model.acc(1'b0, 1'b1, 1'b0, a, 8'h00, q);
    u_cimb_host_model.idle();
  endtask : rd
  task automatic ev(input int l, input logic [7:0] v);
    evs[l] = v;
    @(negedge clk);
    evs[l] = 8'h00;
  endtask : ev
  task automatic test_done();
    $display("%0d compares, %0d bad", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    for (int a = 8'h18; a <= 8'h21; a++) begin
      rd(8'(a));
      chk(q, 8'h00);
      wr(8'(a), 8'hff);
      chk(q, (a < 8'h1d || a > 8'h20) ? 8'h00 : (a == 8'h1e) ? 8'hfe : 8'hff);
    end
    $display("test registers done");
    u_cimb_host_model.acc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, q);
    u_cimb_host_model.idle();
    for (int a = 8'h1d; a <= 8'h20; a++) begin
      rd(8'(a));
      chk(q, 8'h00);
    end
    $display("test register reset done");
    ev(0, 8'h80);
    rd(8'h18);
    chk(q, 8'h80);
    // Each flag: held off while masked, irq once unmasked, gone after read
    for (int l = 0; l < 4; l++) begin
      for (int b = 0; b < 8; b++) begin
        m = 8'h01 << b;
        f = m & ((l == 1) ? 8'hf4 : 8'hff);
        wr(8'h1d + 8'(l), m);
        ev(l, m);
        @(negedge clk);
        chk_irq(irq, 1'b0);
        wr(8'h1d + 8'(l), 8'h00);
        chk_irq(irq, |f);
        rd(8'h18 + 8'(l));
        chk(q, f);
        chk_irq(irq, 1'b0);
      end
    end
    $display("test flag masking done");
    test_done();
  end
endmodule : cimb_mask_bank_tb

bind cimb_mask_bank cimb_mask_bank_props u_cimb_mask_bank_props (.clk, .reset, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rd, .reg_rdata, .reg_reset_cmd, .protect_events, .bus_current_events, .input_presence_events,
  .thermal_adc_events, .irq);
